// File: hdl/ddb_pkg.sv
// Shared constants and types for the command-decode / bank-control link.
// Assumes a single 125 MHz clock shared by both ends.
package ddb_pkg;
  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W  = 13;
  localparam int BANK_W  = 2;
  localparam int BANKS   = 4;
  localparam int DATA_W  = 16;
  localparam int MASK_W  = 2;
  localparam int COL_HI  = 8;
  localparam int AP_BIT  = 10;
  localparam int COL_EXT = 11;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PS          = 8000;
  localparam int REFI_NS         = 7800;
  localparam int REFI_CYC        = REFI_NS * 1000 / CLK_PS;
  localparam int REF_POST_MAX    = 8;
  localparam int DLL_LOCK_CYC    = 200;
  localparam int MODE_LOAD_NS    = 16;
  localparam int MODE_LOAD_CYC   = (MODE_LOAD_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int PRECHARGE_NS    = 20;
  localparam int PRECHARGE_CYC   = (PRECHARGE_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int BURST_CYC       = 2;
  localparam logic [BANK_W-1:0] MODE_BASE = 2'h0;
  localparam logic [BANK_W-1:0] MODE_EXT  = 2'h1;
  // ----------------------------------------------------------------
  // Command codes {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------------------------------
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD  = 4'h5;
  localparam logic [3:0] CMD_WR  = 4'h4;
  localparam logic [3:0] CMD_BT  = 4'h6;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRL = 4'h0;
  localparam logic [3:0] CMD_DES = 4'h8;
  typedef enum {DDB_NOP, DDB_ACT, DDB_RD, DDB_WR, DDB_BT, DDB_PRE, DDB_REF, DDB_SREF, DDB_MRL} ddb_cmd_e;
  typedef enum {BK_IDLE, BK_ACTIVE, BK_PRECHARGING} ddb_bank_e;
endpackage

// File: hdl/ddb_link_if.sv
// Command link between the controller end and the memory end.
// Assumes both ends run on the same core_clk.
`timescale 1ns/1ps
interface ddb_link_if;
  import ddb_pkg::*;
  logic              clkEn;
  logic              selN;
  logic              rowStrobeN;
  logic              colStrobeN;
  logic              writeEnN;
  logic [BANK_W-1:0] bankAddr;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wrData;
  logic [MASK_W-1:0] writeDataMask;
  logic [DATA_W-1:0] rdData;
  logic              rdValid;
  modport ctrl (output clkEn, selN, rowStrobeN, colStrobeN, writeEnN, bankAddr, addr, wrData,
                writeDataMask, input rdData, rdValid);
  modport mem  (input clkEn, selN, rowStrobeN, colStrobeN, writeEnN, bankAddr, addr, wrData,
                writeDataMask, output rdData, rdValid);
endinterface

// File: hdl/ddb_mem_end.sv
// Memory end: decodes link commands, keeps per-bank state, small array.
// Assumes the controller end keeps its own timing obligations.
`timescale 1ns/1ps
// Contract
// - No-op changes no state
// - Mode load only when idle, then wait
// - Activate takes bank and row
// - Close bank before opening another row
// - Column from low address bits
// - Address bit ten selects per-access autoclose
// - Autoclose precharges at burst end
// - Mask high discards write byte
// - Precharge one or all banks
// - Precharged bank idle after recovery
// - Precharge to closed bank is no-op
// - Wait recovery after autoclose access
// - Truncate truncates latest read only
// - Refresh uses internal counter
// - At most eight refreshes postponed
// - Self refresh ignores inputs but enable
// - Loop off in self refresh, relock
// - Exit self refresh with no-ops
// - Basic command encodings
// - Further command encodings
// - Refresh meaning depends on enable
// - Mode load selects base or extended
// - Deselect executes nothing new
module ddb_mem_end #(
  parameter int COLS = 16
) (
  // Clock and reset
  input  wire logic                          core_clk,
  input  wire logic                          reset,
  // Link
  ddb_link_if.mem                            link,
  // Status
  output logic [ddb_pkg::BANKS-1:0]          bankOpen,
  output logic                               selfRefresh,
  output logic                               dllLocked,
  output logic [ddb_pkg::ADDR_W-1:0]         modeBase,
  output logic [ddb_pkg::ADDR_W-1:0]         modeExt,
  output logic [ddb_pkg::ADDR_W-1:0]         refreshRow
);
  import ddb_pkg::*;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  function automatic ddb_cmd_e decode(input logic en, input logic [3:0] c);
    if (c[3]) return DDB_NOP;
    case (c)
      CMD_REF: return en ? DDB_REF : DDB_SREF;
      CMD_ACT: return en ? DDB_ACT : DDB_NOP;
      CMD_RD:  return en ? DDB_RD : DDB_NOP;
      CMD_WR:  return en ? DDB_WR : DDB_NOP;
      CMD_BT:  return en ? DDB_BT : DDB_NOP;
      CMD_PRE: return en ? DDB_PRE : DDB_NOP;
      CMD_MRL: return en ? DDB_MRL : DDB_NOP;
      default: return DDB_NOP;
    endcase
  endfunction

  logic [3:0] cmdBits;
  ddb_cmd_e   cmd;
  logic       active;
  assign cmdBits = {link.selN, link.rowStrobeN, link.colStrobeN, link.writeEnN};
  // Self refresh swallows everything; only the enable matters there
  assign active  = !selfRefresh;
  assign cmd     = active ? decode(link.clkEn, cmdBits) : DDB_NOP;

  // ----------------------------------------------------------------
  // Bank state
  // ----------------------------------------------------------------
  ddb_bank_e                      bankSt_q [BANKS];
  logic [ADDR_W-1:0]              openRow_q [BANKS];
  logic [3:0]                     bankCnt_q [BANKS];
  logic [BANKS-1:0]               autoClose_q;
  logic [$clog2(BURST_CYC+1)-1:0] burstCnt_q;
  logic [BANK_W-1:0]              burstBank_q;
  logic                           burstRead_q;
  logic                           burstOn_q;
  logic [ADDR_W-1:0]              burstCol_q;

  genvar b;
  generate
    for (b = 0; b < BANKS; b++) begin : g_bank
      logic hit;
      logic autoEnd;
      assign hit     = (link.bankAddr == BANK_W'(b)) || link.addr[AP_BIT];
      assign autoEnd = burstOn_q && burstCnt_q == 1 && burstBank_q == BANK_W'(b) && autoClose_q[b];
      assign bankOpen[b] = bankSt_q[b] == BK_ACTIVE;
      always_ff @(posedge core_clk) begin
        if (reset) begin
          bankSt_q[b]  <= BK_IDLE;
          openRow_q[b] <= '0;
          bankCnt_q[b] <= '0;
        end else begin
          case (bankSt_q[b])
            BK_IDLE: begin
              if (cmd == DDB_ACT && link.bankAddr == BANK_W'(b)) begin
                bankSt_q[b]  <= BK_ACTIVE;
                openRow_q[b] <= link.addr;
              end
            end
            BK_ACTIVE: begin
              if ((cmd == DDB_PRE && hit) || autoEnd) begin
                bankSt_q[b]  <= BK_PRECHARGING;
                bankCnt_q[b] <= 4'(PRECHARGE_CYC);
              end
            end
            BK_PRECHARGING: begin
              // Further precharges here fall through as no-ops
              bankCnt_q[b] <= bankCnt_q[b] - 4'h1;
              if (bankCnt_q[b] <= 4'h1) bankSt_q[b] <= BK_IDLE;
            end
            default: bankSt_q[b] <= BK_IDLE;
          endcase
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Bursts
  // ----------------------------------------------------------------
  logic accessOk;
  logic [ADDR_W-1:0] colAddr;
  assign accessOk = (cmd == DDB_RD || cmd == DDB_WR) && bankSt_q[link.bankAddr] == BK_ACTIVE;
  assign colAddr  = ADDR_W'(link.addr[COL_HI:0]);

  always_ff @(posedge core_clk) begin
    if (reset) begin
      burstOn_q   <= 1'b0;
      burstCnt_q  <= '0;
      burstBank_q <= '0;
      burstRead_q <= 1'b0;
      burstCol_q  <= '0;
      autoClose_q <= '0;
    end else if (accessOk) begin
      burstOn_q   <= 1'b1;
      burstCnt_q  <= ($bits(burstCnt_q))'(BURST_CYC);
      burstBank_q <= link.bankAddr;
      burstRead_q <= cmd == DDB_RD;
      burstCol_q  <= colAddr;
      autoClose_q[link.bankAddr] <= link.addr[AP_BIT];
    end else if (cmd == DDB_BT && burstRead_q && burstOn_q) begin
      burstOn_q <= 1'b0;
    end else if (burstOn_q) begin
      burstCnt_q <= burstCnt_q - 1'b1;
      burstCol_q <= burstCol_q + 1'b1;
      if (burstCnt_q == 1) begin
        burstOn_q <= 1'b0;
        autoClose_q[burstBank_q] <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Storage: one word per bank and column; rows are folded away
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] mem_q [BANKS*COLS];
  logic [$clog2(BANKS*COLS)-1:0] memIdx;
  assign memIdx = {burstBank_q, burstCol_q[$clog2(COLS)-1:0]};

  always_ff @(posedge core_clk) begin
    if (burstOn_q && !burstRead_q) begin
      for (int i = 0; i < MASK_W; i++) begin
        if (!link.writeDataMask[i]) mem_q[memIdx][i*8 +: 8] <= link.wrData[i*8 +: 8];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      link.rdData  <= '0;
      link.rdValid <= 1'b0;
    end else begin
      link.rdValid <= burstOn_q && burstRead_q;
      link.rdData  <= (burstOn_q && burstRead_q) ? mem_q[memIdx] : '0;
    end
  end

  // ----------------------------------------------------------------
  // Mode registers, refresh, self refresh
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk) begin
    if (reset) begin
      modeBase <= '0;
      modeExt  <= '0;
    end else if (cmd == DDB_MRL) begin
      if (link.bankAddr == MODE_BASE) modeBase <= link.addr;
      else if (link.bankAddr == MODE_EXT) modeExt <= link.addr;
    end
  end

  logic [7:0] dllCnt_q;
  always_ff @(posedge core_clk) begin
    if (reset) begin
      refreshRow  <= '0;
      selfRefresh <= 1'b0;
      dllLocked   <= 1'b1;
      dllCnt_q    <= '0;
    end else begin
      if (cmd == DDB_REF) refreshRow <= refreshRow + 1'b1;
      if (cmd == DDB_SREF) begin
        selfRefresh <= 1'b1;
        dllLocked   <= 1'b0;
      end else if (selfRefresh && link.clkEn) begin
        selfRefresh <= 1'b0;
        dllCnt_q    <= 8'(DLL_LOCK_CYC);
      end else if (!selfRefresh && !dllLocked) begin
        dllCnt_q <= dllCnt_q - 8'h1;
        if (dllCnt_q <= 8'h1) dllLocked <= 1'b1;
      end
      if (selfRefresh && !link.clkEn) refreshRow <= refreshRow + 1'b1;
    end
  end
endmodule

// File: hdl/ddb_ctrl_end.sv
// Controller end: turns user requests into timed link commands.
// Assumes the user waits for ready before each request.
`timescale 1ns/1ps
module ddb_ctrl_end #(
  parameter int REFI = ddb_pkg::REFI_CYC
) (
  // Clock and reset
  input  wire logic                      core_clk,
  input  wire logic                      reset,
  // User request
  input  wire logic                      reqValid,
  input  wire logic [3:0]                reqCmd,
  input  wire logic [ddb_pkg::BANK_W-1:0] reqBank,
  input  wire logic [ddb_pkg::ADDR_W-1:0] reqAddr,
  input  wire logic [ddb_pkg::DATA_W-1:0] reqData,
  input  wire logic [ddb_pkg::MASK_W-1:0] reqMask,
  input  wire logic                      reqSelfExit,
  output logic                           reqReady,
  // Read return
  output logic [ddb_pkg::DATA_W-1:0]     rdData,
  output logic                           rdValid,
  // Link
  ddb_link_if.ctrl                       link
);
  import ddb_pkg::*;

  // ----------------------------------------------------------------
  // Pacing
  // ----------------------------------------------------------------
  logic [7:0]  waitCnt_q;
  logic [15:0] refCnt_q;
  logic        inSelf_q;
  logic        refDue;
  assign refDue   = refCnt_q >= 16'(REFI);
  assign reqReady = waitCnt_q == 0 && !inSelf_q && !refDue;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      waitCnt_q <= '0;
      refCnt_q  <= '0;
      inSelf_q  <= 1'b0;
      link.clkEn      <= 1'b1;
      link.selN       <= 1'b1;
      link.rowStrobeN <= 1'b1;
      link.colStrobeN <= 1'b1;
      link.writeEnN   <= 1'b1;
      link.bankAddr   <= '0;
      link.addr       <= '0;
      link.wrData     <= '0;
      link.writeDataMask <= '0;
    end else begin
      {link.selN, link.rowStrobeN, link.colStrobeN, link.writeEnN} <= CMD_NOP;
      link.wrData        <= reqData;
      link.writeDataMask <= reqMask;
      if (waitCnt_q != 0) waitCnt_q <= waitCnt_q - 8'h1;
      if (!inSelf_q) refCnt_q <= refCnt_q + 16'h1;
      if (inSelf_q) begin
        if (reqSelfExit) begin
          inSelf_q   <= 1'b0;
          link.clkEn <= 1'b1;
          waitCnt_q  <= 8'(DLL_LOCK_CYC);
        end
      end else if (waitCnt_q == 0 && refDue) begin
        {link.selN, link.rowStrobeN, link.colStrobeN, link.writeEnN} <= CMD_REF;
        refCnt_q  <= '0;
        waitCnt_q <= 8'(PRECHARGE_CYC);
      end else if (reqValid && reqReady) begin
        {link.selN, link.rowStrobeN, link.colStrobeN, link.writeEnN} <= reqCmd;
        link.bankAddr <= reqBank;
        link.addr     <= reqAddr;
        case (reqCmd)
          CMD_MRL: waitCnt_q <= 8'(MODE_LOAD_CYC);
          CMD_PRE: waitCnt_q <= 8'(PRECHARGE_CYC);
          CMD_RD, CMD_WR: waitCnt_q <= reqAddr[AP_BIT] ? 8'(BURST_CYC + PRECHARGE_CYC) : 8'(BURST_CYC);
          CMD_REF: begin
            if (reqSelfExit == 1'b0 && reqData[0]) begin
              link.clkEn <= 1'b0;
              inSelf_q   <= 1'b1;
            end
          end
          default: waitCnt_q <= 8'h0;
        endcase
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      rdData  <= '0;
      rdValid <= 1'b0;
    end else begin
      rdData  <= link.rdData;
      rdValid <= link.rdValid;
    end
  end
endmodule

// File: bench/ddb_link_assertions.sv
// Concurrent checks on the command link between the two ends.
// Assumes the top module instantiates it beside the link, on core_clk.
`timescale 1ns/1ps
module ddb_link_assertions #(
  parameter int REFI = ddb_pkg::REFI_CYC
) (
  // Clock and reset
  input wire logic                       core_clk,
  input wire logic                       reset,
  // Link command
  input wire logic                       clkEn,
  input wire logic                       selN,
  input wire logic                       rowStrobeN,
  input wire logic                       colStrobeN,
  input wire logic                       writeEnN,
  input wire logic [ddb_pkg::ADDR_W-1:0] addr,
  // Link read return
  input wire logic                       rdValid
);
  import ddb_pkg::*;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic [3:0] cmd;
  logic       idle;
  logic       isRd;
  int         gapCnt_q;
  int         exitCnt_q;
  assign cmd  = {selN, rowStrobeN, colStrobeN, writeEnN};
  assign idle = selN || (cmd == CMD_NOP);
  assign isRd = clkEn && (cmd == CMD_RD);
  // Cleared in self refresh, where no refresh is owed
  always_ff @(posedge core_clk) begin
    if (reset || !clkEn || cmd == CMD_REF) begin
      gapCnt_q <= 0;
    end else begin
      gapCnt_q <= gapCnt_q + 1;
    end
  end
  // Saturates, so reads long after reset or after an exit pass freely
  always_ff @(posedge core_clk) begin
    if (reset) begin
      exitCnt_q <= DLL_LOCK_CYC;
    end else if (!clkEn) begin
      exitCnt_q <= 0;
    end else if (exitCnt_q < DLL_LOCK_CYC) begin
      exitCnt_q <= exitCnt_q + 1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_mode_load_gap: assert property ((clkEn && cmd == CMD_MRL) |=> idle [*2])
    else $error("command too soon after mode load");
  a_precharge_gap: assert property ((clkEn && cmd == CMD_PRE) |=> idle [*2])
    else $error("command too soon after precharge");
  a_autoclose_gap: assert property ((clkEn && (cmd == CMD_RD || cmd == CMD_WR) && addr[AP_BIT]) |=> idle [*4])
    else $error("command too soon after autoclose access");
  a_read_two_beats: assert property (isRd |-> ##[1:3] rdValid ##1 rdValid)
    else $error("read burst did not return two beats");
  a_read_cause: assert property ($rose(rdValid) |-> ($past(isRd, 1) || $past(isRd, 2) || $past(isRd, 3)))
    else $error("read data without a read");
  a_selfref_entry: assert property ($fell(clkEn) |-> cmd == CMD_REF)
    else $error("enable fell without refresh code");
  a_selfref_quiet: assert property ((!clkEn && !$fell(clkEn)) |-> idle)
    else $error("command while enable low");
  a_exit_nops: assert property ($rose(clkEn) |-> idle [*8])
    else $error("command too soon after self refresh exit");
  a_refresh_gap: assert property (gapCnt_q <= 9 * REFI)
    else $error("refresh gap too long");
  a_read_after_exit: assert property (isRd |-> exitCnt_q >= DLL_LOCK_CYC)
    else $error("read too soon after self refresh exit");
  c_truncate: cover property (clkEn && cmd == CMD_BT);
  c_selfref: cover property ($fell(clkEn));
  c_autoclose_rd: cover property (isRd && addr[AP_BIT]);
  c_precharge_all: cover property (clkEn && cmd == CMD_PRE && addr[AP_BIT]);
endmodule

// File: bench/tb.sv
// Self-checking bench: user requests into the controller end, status from the memory end.
// Assumes a 125 MHz core_clk and a shortened refresh interval.
`timescale 1ns/1ps
module tb;
  import ddb_pkg::*;
  localparam int REFI_T = 50;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic                core_clk = 1'b0;
  logic                reset    = 1'b1;
  logic                reqValid = 1'b0;
  logic [3:0]          reqCmd   = CMD_NOP;
  logic [BANK_W-1:0]   reqBank  = 2'h0;
  logic [ADDR_W-1:0]   reqAddr  = 13'h0;
  logic [DATA_W-1:0]   reqData  = 16'h0;
  logic [MASK_W-1:0]   reqMask  = 2'h0;
  logic                reqSelfExit = 1'b0;
  logic                reqReady, rdValid, selfRefresh, dllLocked;
  logic [DATA_W-1:0]   rdData;
  logic [BANKS-1:0]    bankOpen;
  logic [ADDR_W-1:0]   modeBase, modeExt, refreshRow, oldRow;
  logic [DATA_W-1:0]   rdQ[$];
  int                  errors = 0;
  int                  samplesChecked = 0;
  always #4 core_clk = ~core_clk;
  ddb_link_if link ();
  ddb_ctrl_end #(.REFI(REFI_T)) ddb_ctrl_end_inst (.core_clk(core_clk), .reset(reset), .reqValid(reqValid),
    .reqCmd(reqCmd), .reqBank(reqBank), .reqAddr(reqAddr), .reqData(reqData), .reqMask(reqMask),
    .reqSelfExit(reqSelfExit), .reqReady(reqReady), .rdData(rdData), .rdValid(rdValid), .link(link));
  ddb_mem_end ddb_mem_end_inst (.core_clk(core_clk), .reset(reset), .link(link), .bankOpen(bankOpen),
    .selfRefresh(selfRefresh), .dllLocked(dllLocked), .modeBase(modeBase), .modeExt(modeExt),
    .refreshRow(refreshRow));
  ddb_link_assertions #(.REFI(REFI_T)) ddb_link_assertions_inst (.core_clk(core_clk), .reset(reset),
    .clkEn(link.clkEn), .selN(link.selN), .rowStrobeN(link.rowStrobeN), .colStrobeN(link.colStrobeN),
    .writeEnN(link.writeEnN), .addr(link.addr), .rdValid(link.rdValid));
  always @(posedge core_clk) if (rdValid === 1'b1) rdQ.push_back(rdData);
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samplesChecked, errors);
    if (errors == 0 && samplesChecked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Data and mask reach the link one edge late, so they stay held until both burst beats took them
  task automatic req(input logic [3:0] c, input logic [1:0] b, input logic [12:0] a, input logic [15:0] d,
                     input logic [1:0] m);
    int n;
    n = 0;
    reqValid <= 1'b1; reqCmd <= c; reqBank <= b; reqAddr <= a; reqData <= d; reqMask <= m;
    @(posedge core_clk);
    while (reqReady !== 1'b1 && n < 1000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 1000) chk(16'h0, 16'h1);
    reqValid <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic rd(input logic [1:0] b, input logic [12:0] a, input logic [15:0] e, input logic [15:0] e1);
    int n;
    n = 0;
    rdQ.delete();
    req(CMD_RD, b, a, reqData, reqMask);
    while (rdQ.size() < 2 && n < 50) begin
      @(posedge core_clk);
      n++;
    end
    chk((rdQ.size() >= 2) ? rdQ[0] : 16'hdead, e);
    chk((rdQ.size() >= 2) ? rdQ[1] : 16'hdead, e1);
  endtask
  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    int n;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    chk({12'h0, bankOpen}, 16'h0);
    chk({14'h0, selfRefresh, dllLocked}, 16'h1);
    $display("test reset done");
    req(CMD_MRL, 2'h0, 13'h0123, 16'h0, 2'h0);
    req(CMD_MRL, 2'h1, 13'h0456, 16'h0, 2'h0);
    req(CMD_MRL, 2'h2, 13'h0aaa, 16'h0, 2'h0);
    req(CMD_DES, 2'h0, 13'h0777, 16'h0, 2'h0);
    req(CMD_NOP, 2'h0, 13'h0999, 16'h0, 2'h0);
    chk({3'h0, modeBase}, 16'h0123);
    chk({3'h0, modeExt}, 16'h0456);
    $display("test mode load done");
    req(CMD_ACT, 2'h1, 13'h0005, 16'h0, 2'h0);
    chk({12'h0, bankOpen}, 16'h2);
    req(CMD_WR, 2'h1, 13'h0000, 16'h1234, 2'h0);
    req(CMD_WR, 2'h1, 13'h0000, 16'habcd, 2'h2);
    req(CMD_WR, 2'h1, 13'h0002, 16'h5a5a, 2'h0);
    rd(2'h1, 13'h0000, 16'h12cd, 16'h12cd);
    rd(2'h1, 13'h0002, 16'h5a5a, 16'h5a5a);
    chk({12'h0, bankOpen}, 16'h2);
    rd(2'h1, 13'h0400, 16'h12cd, 16'h12cd);
    repeat (8) @(posedge core_clk);
    chk({12'h0, bankOpen}, 16'h0);
    $display("test access done");
    req(CMD_ACT, 2'h0, 13'h0001, 16'h0, 2'h0);
    req(CMD_ACT, 2'h2, 13'h0002, 16'h0, 2'h0);
    req(CMD_ACT, 2'h3, 13'h0003, 16'h0, 2'h0);
    req(CMD_PRE, 2'h2, 13'h0000, 16'h0, 2'h0);
    repeat (6) @(posedge core_clk);
    chk({12'h0, bankOpen}, 16'h9);
    req(CMD_PRE, 2'h2, 13'h0000, 16'h0, 2'h0);
    repeat (6) @(posedge core_clk);
    chk({12'h0, bankOpen}, 16'h9);
    req(CMD_PRE, 2'h2, 13'h0400, 16'h0, 2'h0);
    repeat (6) @(posedge core_clk);
    chk({12'h0, bankOpen}, 16'h0);
    $display("test precharge done");
    oldRow = refreshRow;
    req(CMD_REF, 2'h3, 13'h1fff, 16'h0, 2'h0);
    repeat (4) @(posedge core_clk);
    chk({15'h0, refreshRow !== oldRow}, 16'h1);
    repeat (3 * REFI_T) @(posedge core_clk);
    req(CMD_REF, 2'h0, 13'h0000, 16'h0001, 2'h0);
    repeat (20) @(posedge core_clk);
    chk({14'h0, selfRefresh, dllLocked}, 16'h2);
    reqSelfExit <= 1'b1;
    @(posedge core_clk);
    reqSelfExit <= 1'b0;
    n = 0;
    while ((dllLocked !== 1'b1 || reqReady !== 1'b1) && n < 1000) begin
      @(posedge core_clk);
      n++;
    end
    chk({14'h0, selfRefresh, dllLocked}, 16'h1);
    req(CMD_ACT, 2'h1, 13'h0005, 16'h0, 2'h0);
    rd(2'h1, 13'h0002, 16'h5a5a, 16'h5a5a);
    req(CMD_BT, 2'h1, 13'h0000, 16'h0, 2'h0);
    chk({12'h0, bankOpen}, 16'h2);
    rd(2'h1, 13'h0000, 16'h12cd, 16'h12cd);
    $display("test refresh done");
    end_sim();
  end
  // Generous next to the several hundred cycles the tests take
  initial begin
    #400000;
    errors++;
    end_sim();
  end
endmodule
